// ### logic/limit_comp_regs.svh
`ifndef LIMIT_COMP_REGS_SVH
`define LIMIT_COMP_REGS_SVH

// Register byte offsets
`define OFS_CTRL 12'h000
`define OFS_LIMIT 12'h004
`define OFS_COMP0 12'h008
`define OFS_COMP1 12'h00c
`define OFS_BLANK 12'h010
`define OFS_STATUS 12'h014

// Control bit positions
`define CTRL_LIM_OVR 0
`define CTRL_COMP_OVR 1
`define CTRL_ADAPT 2
`define CTRL_BLANK_OVR 3
`define CTRL_FAST_EN 4

// Write masks and reset values
`define CTRL_MASK 32'h0000_001f
`define LIMIT_MASK 32'h0000_03ff
`define COMP_MASK 32'h0000_ffff
`define BLANK_MASK 32'h0000_0fff
`define CTRL_RESET 32'h0000_0010
`define LIMIT_RESET 32'h0000_0028
`define COMP_RESET 32'h0000_0000
`define BLANK_RESET 32'h0000_0511

// Status field positions
`define ST_METHOD 8
`define ST_VIOL 10
`define ST_RSVD 14
`define ST_SET1 15
`define ST_COMP 16
`define ST_BLANK 24

// Timing: clock period and blanking defaults
`define PCLK_NS 40
`define BLANK_RDS_NS 672
`define BLANK_DCR_NS 352
`define BLANK_RDS_CYC (8'((`BLANK_RDS_NS + `PCLK_NS - 1) / `PCLK_NS))
`define BLANK_DCR_CYC (8'((`BLANK_DCR_NS + `PCLK_NS - 1) / `PCLK_NS))
`define VIOL_DEFAULT 4'h5

// Threshold in half-millivolt units
`define GRID_BASE_HMV 8'h28
`define GRID_STEP_A_HMV 8'h14
`define GRID_STEP_B_HMV 8'h3c
`define RES_STEP_HMV 8'h0a
`define RES_HALF_HMV 8'h05
`define RES_CODE_MAX 5'h18

// Fast path hold defaults per resonance band
`define FAST_HOLD_B0 8'h10
`define FAST_HOLD_B1 8'h0c
`define FAST_HOLD_B2 8'h08

`endif

// ### logic/limit_comp_pkg.sv
package limit_comp_pkg;

  // Three-level strap, or a resistor to ground
  typedef enum logic [1:0] {
    LVL_LOW = 2'h0,
    LVL_OPEN = 2'h1,
    LVL_HIGH = 2'h2,
    LVL_RES = 2'h3
  } strap_level_t;

  typedef enum logic [1:0] {
    SENSE_RDS = 2'h0,
    SENSE_DCR_DOWN = 2'h1,
    SENSE_DCR_UP = 2'h2
  } sense_method_t;

  typedef enum logic [2:0] {
    FP_IDLE = 3'h1,
    FP_BOOST = 3'h2,
    FP_SINK = 3'h4
  } fast_state_t;

  typedef struct packed {
    logic [3:0] zero_b;
    logic [3:0] zero_a;
  } comp_t;

  typedef struct packed {
    sense_method_t method;
    logic [7:0] thr_hmv;
    logic [3:0] viol;
    logic [7:0] blank;
  } limit_cfg_t;

endpackage

// ### logic/coef_blend.sv
`timescale 1ns/10ps
// Linear blend between two coefficient codes by load weight
module coef_blend #(
  parameter int W = 4
) (
  input wire logic [W-1:0] from_set,
  input wire logic [W-1:0] to_set,
  input wire logic [7:0] weight,
  output logic [W-1:0] blended
);
  logic signed [W:0] diff;
  logic signed [W+9:0] prod;
  logic signed [W+9:0] mix;

  // Result stays between the two codes, so no clamp needed
  assign diff = $signed({1'b0, to_set}) - $signed({1'b0, from_set});
  assign prod = diff * $signed({1'b0, weight});
  assign mix = $signed({10'h000, from_set}) + (prod >>> 8);
  assign blended = mix[W-1:0];
endmodule

// ### logic/limit_comp_cfg.sv
// Added by the designer: the register offsets and register access over APB.
`timescale 1ns/10ps
`include "limit_comp_regs.svh"
// What this block does
// - Skip current measurement during blanking window
// - Strap grid picks 20 to 100 mV
// - Grid straps imply ground-referenced on-resistance sensing
// - Resistor strap: 5 mV steps, half for inductor
// - Host threshold replaces strap threshold
// - Fixed-frequency PWM from integrated error
// - Compensation zeros from straps unless host set
// - First strap selects resonance band
// - Second strap selects capacitor zero, low reserved
// - Strap settings target fsw/20, 60 degrees
// - Host write may store second coefficient set
// - Adaptive mode blends sets by load current
// - Fast path bypasses loop outside limits
// - Undervoltage: fast path turns on upper switch
// - Load release: fast path turns on lower switch
// - Fast path defaults follow compensation band
// - Strap sensing applies default count and blanking
// - Blanking 672 ns on-resistance, 352 ns inductor
module limit_comp_cfg (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input limit_comp_pkg::strap_level_t limit_strap_a,
  input limit_comp_pkg::strap_level_t limit_strap_b,
  input wire logic [4:0] limit_strap_resistor,
  input limit_comp_pkg::strap_level_t comp_strap_a,
  input limit_comp_pkg::strap_level_t comp_strap_b,
  input wire logic cur_sample_valid,
  input wire logic load_step,
  input wire logic [7:0] load_current,
  input wire logic err_valid,
  input wire logic signed [11:0] err_sample,
  input wire logic vout_below_low,
  input wire logic vout_load_release,
  output logic meas_take,
  output limit_comp_pkg::limit_cfg_t limit_cfg,
  output limit_comp_pkg::comp_t comp_active,
  output logic comp_strap_reserved,
  output logic fast_transient_path,
  output logic gate_high,
  output logic gate_low
);
  logic [31:0] ctrl;
  logic [31:0] lim_reg;
  logic [31:0] comp0;
  logic [31:0] comp1;
  logic [31:0] blank_reg;
  logic set1_valid;
  logic data_ok;
  logic wr_en;
  logic addr_hit;
  logic [31:0] rd_data;
  logic straps_loaded;
  limit_comp_pkg::strap_level_t lim_a_q;
  limit_comp_pkg::strap_level_t lim_b_q;
  limit_comp_pkg::strap_level_t comp_a_q;
  limit_comp_pkg::strap_level_t comp_b_q;
  logic [4:0] res_code;
  limit_comp_pkg::sense_method_t strap_method;
  logic [7:0] strap_thr;
  limit_comp_pkg::comp_t strap_comp;
  limit_comp_pkg::comp_t blend_comp;
  logic [7:0] fast_hold;
  logic [7:0] blank_cnt;
  logic restart;
  logic gate_high_d;
  logic [7:0] pwm_cnt;
  logic [7:0] duty;
  logic [7:0] next_duty;
  logic signed [12:0] duty_sum;
  logic [2:0] err_shift;
  limit_comp_pkg::fast_state_t fast_state;
  logic [7:0] hold_cnt;

  // APB: answer once read data is captured, frozen while ce low
  assign pready = ce & penable & data_ok;
  assign wr_en = psel & penable & pready & pwrite;
  assign pslverr = psel & pready & ~addr_hit;

  // Address decode
  always_comb
  begin
    case (paddr)
      `OFS_CTRL, `OFS_LIMIT, `OFS_COMP0, `OFS_COMP1, `OFS_BLANK, `OFS_STATUS:
        addr_hit = 1'b1;
      default:
        addr_hit = 1'b0;
    endcase
  end

  // Read mux, unmapped reads zero
  always_comb
  begin
    case (paddr)
      `OFS_CTRL: rd_data = ctrl;
      `OFS_LIMIT: rd_data = lim_reg;
      `OFS_COMP0: rd_data = comp0;
      `OFS_COMP1: rd_data = comp1;
      `OFS_BLANK: rd_data = blank_reg;
      `OFS_STATUS:
      begin
        rd_data = 32'h0000_0000;
        rd_data[7:0] = limit_cfg.thr_hmv;
        rd_data[`ST_METHOD +: 2] = limit_cfg.method;
        rd_data[`ST_VIOL +: 4] = limit_cfg.viol;
        rd_data[`ST_RSVD] = comp_strap_reserved;
        rd_data[`ST_SET1] = set1_valid;
        rd_data[`ST_COMP +: 8] = comp_active;
        rd_data[`ST_BLANK +: 8] = limit_cfg.blank;
      end
      default: rd_data = 32'h0000_0000;
    endcase
  end

  // Read data captured before the access edge so it comes from a flop
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
      data_ok <= 1'b0;
    end
    else if (ce)
    begin
      prdata <= psel ? rd_data : 32'h0000_0000;
      data_ok <= psel & ~(penable & data_ok);
    end
  end

  // Register writes, undefined bits masked off
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl <= `CTRL_RESET;
      lim_reg <= `LIMIT_RESET;
      comp0 <= `COMP_RESET;
      comp1 <= `COMP_RESET;
      blank_reg <= `BLANK_RESET;
      set1_valid <= 1'b0;
    end
    else if (ce && wr_en)
    begin
      case (paddr)
        `OFS_CTRL: ctrl <= pwdata & `CTRL_MASK;
        `OFS_LIMIT: lim_reg <= pwdata & `LIMIT_MASK;
        `OFS_COMP0: comp0 <= pwdata & `COMP_MASK;
        `OFS_COMP1:
        begin
          comp1 <= pwdata & `COMP_MASK;
          set1_valid <= 1'b1;
        end
        `OFS_BLANK: blank_reg <= pwdata & `BLANK_MASK;
        default: ;
      endcase
    end
  end

  // Straps caught once at the first enabled edge after reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      straps_loaded <= 1'b0;
      lim_a_q <= limit_comp_pkg::LVL_OPEN;
      lim_b_q <= limit_comp_pkg::LVL_OPEN;
      comp_a_q <= limit_comp_pkg::LVL_OPEN;
      comp_b_q <= limit_comp_pkg::LVL_OPEN;
      res_code <= 5'h00;
    end
    else if (ce && !straps_loaded)
    begin
      straps_loaded <= 1'b1;
      lim_a_q <= limit_strap_a;
      lim_b_q <= limit_strap_b;
      comp_a_q <= comp_strap_a;
      comp_b_q <= comp_strap_b;
      // Codes past 120 mV are clamped, not wrapped
      res_code <= (limit_strap_resistor > `RES_CODE_MAX) ? `RES_CODE_MAX
                                                          : limit_strap_resistor;
    end
  end

  // Strap-derived sensing method and threshold
  always_comb
  begin
    strap_method = limit_comp_pkg::SENSE_RDS;
    strap_thr = `GRID_BASE_HMV;
    if (lim_a_q == limit_comp_pkg::LVL_RES)
    begin
      case (lim_b_q)
        limit_comp_pkg::LVL_OPEN: strap_method = limit_comp_pkg::SENSE_DCR_DOWN;
        limit_comp_pkg::LVL_HIGH: strap_method = limit_comp_pkg::SENSE_DCR_UP;
        default: strap_method = limit_comp_pkg::SENSE_RDS;
      endcase
      if (strap_method == limit_comp_pkg::SENSE_RDS)
        strap_thr = {3'h0, res_code} * `RES_STEP_HMV;
      else
        strap_thr = {3'h0, res_code} * `RES_HALF_HMV;
    end
    else
    begin
      strap_thr = `GRID_BASE_HMV + {6'h00, lim_a_q} * `GRID_STEP_A_HMV;
      if (lim_b_q != limit_comp_pkg::LVL_RES)
        strap_thr = strap_thr + {6'h00, lim_b_q} * `GRID_STEP_B_HMV;
    end
  end

  // Effective current limit settings
  always_comb
  begin
    if (ctrl[`CTRL_LIM_OVR])
    begin
      limit_cfg.method = limit_comp_pkg::sense_method_t'(lim_reg[9:8]);
      limit_cfg.thr_hmv = lim_reg[7:0];
    end
    else
    begin
      limit_cfg.method = strap_method;
      limit_cfg.thr_hmv = strap_thr;
    end
    if (ctrl[`CTRL_BLANK_OVR])
    begin
      limit_cfg.blank = blank_reg[7:0];
      limit_cfg.viol = blank_reg[11:8];
    end
    else
    begin
      limit_cfg.viol = `VIOL_DEFAULT;
      if (limit_cfg.method == limit_comp_pkg::SENSE_RDS)
        limit_cfg.blank = `BLANK_RDS_CYC;
      else
        limit_cfg.blank = `BLANK_DCR_CYC;
    end
  end

  // Strap compensation bands; resistor on a strap reads as open
  always_comb
  begin
    case (comp_a_q)
      limit_comp_pkg::LVL_LOW: strap_comp.zero_a = 4'h0;
      limit_comp_pkg::LVL_HIGH: strap_comp.zero_a = 4'h2;
      default: strap_comp.zero_a = 4'h1;
    endcase
    strap_comp.zero_b = (comp_b_q == limit_comp_pkg::LVL_HIGH) ? 4'h1 : 4'h0;
    comp_strap_reserved = straps_loaded & (comp_b_q == limit_comp_pkg::LVL_LOW);
    case (strap_comp.zero_a)
      4'h0: fast_hold = `FAST_HOLD_B0;
      4'h1: fast_hold = `FAST_HOLD_B1;
      default: fast_hold = `FAST_HOLD_B2;
    endcase
    if (ctrl[`CTRL_COMP_OVR] && comp0[15:8] != 8'h00)
      fast_hold = comp0[15:8];
  end

  coef_blend #(.W(4)) u_blend_a (
    .from_set(comp0[3:0]),
    .to_set(comp1[3:0]),
    .weight(load_current),
    .blended(blend_comp.zero_a)
  );

  coef_blend #(.W(4)) u_blend_b (
    .from_set(comp0[7:4]),
    .to_set(comp1[7:4]),
    .weight(load_current),
    .blended(blend_comp.zero_b)
  );

  // Active compensation: adaptive needs both sets present
  always_comb
  begin
    if (!ctrl[`CTRL_COMP_OVR])
      comp_active = strap_comp;
    else if (ctrl[`CTRL_ADAPT] && set1_valid)
      comp_active = blend_comp;
    else
      comp_active = comp0[7:0];
  end

  // blanking restarts on each upper switch turn-on (gate_high rising) or load step
  assign restart = load_step | (gate_high & ~gate_high_d);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      blank_cnt <= 8'h00;
      gate_high_d <= 1'b0;
      meas_take <= 1'b0;
    end
    else if (ce)
    begin
      gate_high_d <= gate_high;
      if (restart)
        blank_cnt <= limit_cfg.blank;
      else if (blank_cnt != 8'h00)
        blank_cnt <= blank_cnt - 8'h01;
      meas_take <= cur_sample_valid & ~restart & (blank_cnt == 8'h00);
    end
  end

  // Higher zero band gives a larger integrator step
  always_comb
  begin
    err_shift = 3'h4 - {1'b0, comp_active.zero_a[1:0]};
    duty_sum = $signed({5'h00, duty}) + 13'(err_sample >>> err_shift);
    if (duty_sum < 13'sh0000)
      next_duty = 8'h00;
    else if (duty_sum > 13'sh00ff)
      next_duty = 8'hff;
    else
      next_duty = duty_sum[7:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      duty <= 8'h00;
      pwm_cnt <= 8'h00;
    end
    else if (ce)
    begin
      pwm_cnt <= pwm_cnt + 8'h01;
      if (err_valid)
        duty <= next_duty;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fast_state <= limit_comp_pkg::FP_IDLE;
      hold_cnt <= 8'h00;
    end
    else if (ce)
    begin
      case (fast_state)
        limit_comp_pkg::FP_IDLE:
        begin
          hold_cnt <= fast_hold;
          if (ctrl[`CTRL_FAST_EN] && vout_below_low)
            fast_state <= limit_comp_pkg::FP_BOOST;
          else if (ctrl[`CTRL_FAST_EN] && vout_load_release)
            fast_state <= limit_comp_pkg::FP_SINK;
        end
        limit_comp_pkg::FP_BOOST:
        begin
          // Hold limit stops a stuck comparator from locking the switch on
          hold_cnt <= hold_cnt - 8'h01;
          if (!vout_below_low || hold_cnt == 8'h00)
            fast_state <= limit_comp_pkg::FP_IDLE;
        end
        limit_comp_pkg::FP_SINK:
        begin
          hold_cnt <= hold_cnt - 8'h01;
          if (!vout_load_release || hold_cnt == 8'h00)
            fast_state <= limit_comp_pkg::FP_IDLE;
        end
        default: fast_state <= limit_comp_pkg::FP_IDLE;
      endcase
    end
  end

  assign fast_transient_path = (fast_state != limit_comp_pkg::FP_IDLE);

  // Gate drive, one switch at a time
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      gate_high <= 1'b0;
      gate_low <= 1'b0;
    end
    else if (ce)
    begin
      case (fast_state)
        limit_comp_pkg::FP_BOOST:
        begin
          gate_high <= 1'b1;
          gate_low <= 1'b0;
        end
        limit_comp_pkg::FP_SINK:
        begin
          gate_high <= 1'b0;
          gate_low <= 1'b1;
        end
        default:
        begin
          gate_high <= (pwm_cnt < duty);
          gate_low <= ~(pwm_cnt < duty);
        end
      endcase
    end
  end

  property p_blank_gap;
    @(posedge pclk) disable iff (!presetn)
    ce && load_step && limit_cfg.blank > 8'h01 |=> !meas_take ##1 !meas_take;
  endproperty
  a_blank_gap: assert property (p_blank_gap)
    else $error("sample taken inside blanking");

  property p_grid_corners;
    @(posedge pclk) disable iff (!presetn)
    straps_loaded && !ctrl[`CTRL_LIM_OVR] && lim_a_q == lim_b_q
      && lim_a_q != limit_comp_pkg::LVL_RES && lim_a_q != limit_comp_pkg::LVL_OPEN
      |-> limit_cfg.thr_hmv == ((lim_a_q == limit_comp_pkg::LVL_LOW) ? 8'h28 : 8'hc8);
  endproperty
  a_grid_corners: assert property (p_grid_corners)
    else $error("grid corner threshold wrong");

  property p_grid_rds;
    @(posedge pclk) disable iff (!presetn)
    !ctrl[`CTRL_LIM_OVR] && lim_a_q != limit_comp_pkg::LVL_RES
      |-> limit_cfg.method == limit_comp_pkg::SENSE_RDS;
  endproperty
  a_grid_rds: assert property (p_grid_rds)
    else $error("grid strap not using RDS sensing");

  property p_res_dcr_half;
    @(posedge pclk) disable iff (!presetn)
    !ctrl[`CTRL_LIM_OVR] && lim_a_q == limit_comp_pkg::LVL_RES
      && lim_b_q == limit_comp_pkg::LVL_OPEN
      |-> limit_cfg.thr_hmv == {3'h0, res_code} * 8'h05;
  endproperty
  a_res_dcr_half: assert property (p_res_dcr_half)
    else $error("DCR resistor threshold not half");

  property p_host_thr;
    @(posedge pclk) disable iff (!presetn)
    ctrl[`CTRL_LIM_OVR] |-> limit_cfg.thr_hmv == lim_reg[7:0];
  endproperty
  a_host_thr: assert property (p_host_thr)
    else $error("host threshold ignored");

  property p_no_overlap;
    @(posedge pclk) disable iff (!presetn)
    !(gate_high && gate_low);
  endproperty
  a_no_overlap: assert property (p_no_overlap)
    else $error("both switches on");

  property p_boost_high;
    @(posedge pclk) disable iff (!presetn)
    ce && fast_state == limit_comp_pkg::FP_BOOST |=> gate_high && !gate_low;
  endproperty
  a_boost_high: assert property (p_boost_high)
    else $error("boost did not drive upper switch");

  property p_sink_low;
    @(posedge pclk) disable iff (!presetn)
    ce && fast_state == limit_comp_pkg::FP_SINK |=> gate_low && !gate_high;
  endproperty
  a_sink_low: assert property (p_sink_low)
    else $error("sink did not drive lower switch");

  property p_strap_blank;
    @(posedge pclk) disable iff (!presetn)
    !ctrl[`CTRL_BLANK_OVR] && limit_cfg.method != limit_comp_pkg::SENSE_RDS
      |-> limit_cfg.blank == 8'h09 && limit_cfg.viol == 4'h5;
  endproperty
  a_strap_blank: assert property (p_strap_blank)
    else $error("DCR default blanking wrong");

endmodule

// ### tb/power_stage_model.sv
`timescale 1ns/10ps
// Board side: strap wiring, current sense source and switch pair
module power_stage_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] strap_sel,
  input wire logic gate_high,
  input wire logic gate_low,
  output limit_comp_pkg::strap_level_t limit_strap_a,
  output limit_comp_pkg::strap_level_t limit_strap_b,
  output limit_comp_pkg::strap_level_t comp_strap_a,
  output limit_comp_pkg::strap_level_t comp_strap_b,
  output logic cur_sample_valid,
  output logic overlap_seen
);
  // Straps are fixed wiring, changed only across a reset
  assign limit_strap_a = limit_comp_pkg::strap_level_t'(strap_sel[1:0]);
  assign limit_strap_b = limit_comp_pkg::strap_level_t'(strap_sel[3:2]);
  assign comp_strap_a = limit_comp_pkg::strap_level_t'(strap_sel[5:4]);
  assign comp_strap_b = limit_comp_pkg::strap_level_t'(strap_sel[7:6]);

  // Sense samples ready every cycle, so blanking alone gates them
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cur_sample_valid <= 1'b0;
    else
      cur_sample_valid <= 1'b1;
  end

  // Both switches on would short the input supply
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      overlap_seen <= 1'b0;
    else if (gate_high && gate_low)
      overlap_seen <= 1'b1;
  end
endmodule

// ### tb/current_limit_and_loop_comp_config_tb_top.sv
`timescale 1ns/10ps
`include "limit_comp_regs.svh"
module current_limit_and_loop_comp_config_tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:0] strap_sel = 8'h55;
  logic [4:0] res_code = 5'h00;
  logic load_step = 1'b0;
  logic [7:0] load_current = 8'h00;
  logic err_valid = 1'b0;
  logic signed [11:0] err_sample = 12'h000;
  logic vout_below_low = 1'b0;
  logic vout_load_release = 1'b0;
  limit_comp_pkg::strap_level_t limit_strap_a;
  limit_comp_pkg::strap_level_t limit_strap_b;
  limit_comp_pkg::strap_level_t comp_strap_a;
  limit_comp_pkg::strap_level_t comp_strap_b;
  limit_comp_pkg::limit_cfg_t limit_cfg;
  limit_comp_pkg::comp_t comp_active;
  logic cur_sample_valid;
  logic meas_take;
  logic comp_strap_reserved;
  logic fast_transient_path;
  logic gate_high;
  logic gate_low;
  logic overlap_seen;
  logic [31:0] rd;
  logic er;
  int fail_count = 0;
  int check_count = 0;
  int cycles = 0;

  always #20 pclk = ~pclk;

  limit_comp_cfg dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .limit_strap_a(limit_strap_a),
    .limit_strap_b(limit_strap_b), .limit_strap_resistor(res_code),
    .comp_strap_a(comp_strap_a), .comp_strap_b(comp_strap_b),
    .cur_sample_valid(cur_sample_valid), .load_step(load_step),
    .load_current(load_current), .err_valid(err_valid), .err_sample(err_sample),
    .vout_below_low(vout_below_low), .vout_load_release(vout_load_release),
    .meas_take(meas_take), .limit_cfg(limit_cfg), .comp_active(comp_active),
    .comp_strap_reserved(comp_strap_reserved), .fast_transient_path(fast_transient_path),
    .gate_high(gate_high), .gate_low(gate_low));

  power_stage_model board (.pclk(pclk), .presetn(presetn), .strap_sel(strap_sel),
    .gate_high(gate_high), .gate_low(gate_low), .limit_strap_a(limit_strap_a),
    .limit_strap_b(limit_strap_b), .comp_strap_a(comp_strap_a),
    .comp_strap_b(comp_strap_b), .cur_sample_valid(cur_sample_valid),
    .overlap_seen(overlap_seen));

  task automatic close_out;
    if (fail_count == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // A hung handshake ends the run as a failure
  always @(posedge pclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      fail_count++;
      close_out();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One APB transfer; pready and read data taken at the same rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Straps only count when latched after reset release
  task automatic do_reset(input logic [7:0] s, input logic [4:0] r);
    @(posedge pclk);
    presetn <= 1'b0;
    strap_sel <= s;
    res_code <= r;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    @(negedge pclk);
  endtask

  task automatic t_grid;
    for (int a = 0; a < 3; a++)
    begin
      for (int b = 0; b < 3; b++)
      begin
        do_reset(8'(a | (b << 2) | (a << 4) | (b << 6)), 5'h00);
        chk("thr", 40 + 20 * a + 60 * b, limit_cfg.thr_hmv);
        chk("method", limit_comp_pkg::SENSE_RDS, limit_cfg.method);
        chk("blank", (672 + 39) / 40, limit_cfg.blank);
        chk("viol", 5, limit_cfg.viol);
        chk("zero_a", a, comp_active.zero_a);
        chk("zero_b", b == 2, comp_active.zero_b);
        chk("reserved", b == 0, comp_strap_reserved);
      end
    end
  endtask

  task automatic t_resistor;
    for (int b = 0; b < 3; b++)
    begin
      do_reset(8'(3 | (b << 2) | 8'h50), 5'h18);
      chk("res_thr", (b == 0) ? 240 : 120, limit_cfg.thr_hmv);
      chk("res_method", b, limit_cfg.method);
      chk("res_blank", (b == 0) ? 17 : (352 + 39) / 40, limit_cfg.blank);
    end
    do_reset(8'h53, 5'h1f);
    chk("res_clamp", 240, limit_cfg.thr_hmv);
    do_reset(8'h53, 5'h01);
    chk("res_step", 10, limit_cfg.thr_hmv);
  endtask

  task automatic t_blank;
    repeat (4) @(negedge pclk);
    chk("meas_idle", 1, meas_take);
    @(posedge pclk);
    load_step <= 1'b1;
    @(posedge pclk);
    load_step <= 1'b0;
    repeat (14) @(negedge pclk);
    chk("meas_blank", 0, meas_take);
    repeat (8) @(negedge pclk);
    chk("meas_after", 1, meas_take);
  endtask

  task automatic t_fast;
    int low_seen;
    low_seen = 0;
    @(posedge pclk);
    vout_below_low <= 1'b1;
    repeat (3) @(negedge pclk);
    chk("fast_on", 1, fast_transient_path);
    chk("boost_high", 1, gate_high);
    chk("boost_low", 0, gate_low);
    // Hold default bounds a boost even while the comparator stays set
    repeat (24)
    begin
      @(negedge pclk);
      low_seen += (fast_transient_path === 1'b0);
    end
    chk("hold_ends", 1, low_seen > 0);
    @(posedge pclk);
    vout_below_low <= 1'b0;
    vout_load_release <= 1'b1;
    repeat (5) @(negedge pclk);
    chk("sink_low", 1, gate_low);
    chk("sink_high", 0, gate_high);
    @(posedge pclk);
    vout_load_release <= 1'b0;
    repeat (24) @(negedge pclk);
    chk("fast_off", 0, fast_transient_path);
    // Clock enable low freezes the fast path in idle
    @(posedge pclk);
    ce <= 1'b0;
    vout_below_low <= 1'b1;
    repeat (4) @(negedge pclk);
    chk("ce_freeze", 0, fast_transient_path);
    @(posedge pclk);
    vout_below_low <= 1'b0;
    ce <= 1'b1;
  endtask

  task automatic t_pwm;
    int n;
    n = 0;
    repeat (256)
    begin
      @(negedge pclk);
      n += (gate_high === 1'b1);
    end
    chk("duty_zero", 0, n);
    // Two full-scale samples at shift 4 give 2 x 127
    repeat (2)
    begin
      @(posedge pclk);
      err_valid <= 1'b1;
      err_sample <= 12'h7ff;
      @(posedge pclk);
      err_valid <= 1'b0;
    end
    repeat (4) @(posedge pclk);
    n = 0;
    repeat (256)
    begin
      @(negedge pclk);
      n += (gate_high === 1'b1);
    end
    chk("duty_254", 254, n);
  endtask

  task automatic t_regs;
    apb(1'b0, `OFS_CTRL, 32'h0000_0000);
    chk("ctrl_reset", 32'h0000_0010, rd);
    apb(1'b0, `OFS_BLANK, 32'h0000_0000);
    chk("blank_reset", 32'h0000_0511, rd);
    apb(1'b0, 12'h020, 32'h0000_0000);
    chk("unmapped_err", 1, er);
    chk("unmapped_rd", 0, rd);
    apb(1'b1, `OFS_LIMIT, 32'h0000_0064);
    @(negedge pclk);
    chk("thr_strap", 40, limit_cfg.thr_hmv);
    apb(1'b1, `OFS_CTRL, 32'h0000_0011);
    @(negedge pclk);
    chk("thr_host", 8'h64, limit_cfg.thr_hmv);
    apb(1'b0, `OFS_STATUS, 32'h0000_0000);
    chk("status_thr", 32'h0000_0064, rd & 32'h0000_00ff);
    // Host blanking and violation count replace the defaults
    apb(1'b1, `OFS_BLANK, 32'h0000_0302);
    apb(1'b1, `OFS_CTRL, 32'h0000_0019);
    @(negedge pclk);
    chk("blank_host", 32'h0000_0302, {limit_cfg.viol, limit_cfg.blank});
  endtask

  task automatic t_adapt;
    apb(1'b1, `OFS_COMP0, 32'h0000_0021);
    apb(1'b1, `OFS_COMP1, 32'h0000_0065);
    apb(1'b1, `OFS_CTRL, 32'h0000_0012);
    @(negedge pclk);
    chk("comp_host", 8'h21, comp_active);
    apb(1'b1, `OFS_CTRL, 32'h0000_0016);
    @(posedge pclk);
    load_current <= 8'h80;
    @(negedge pclk);
    chk("blend_half", 8'h43, comp_active);
    @(posedge pclk);
    load_current <= 8'h00;
    @(negedge pclk);
    chk("blend_zero", 8'h21, comp_active);
    apb(1'b0, `OFS_STATUS, 32'h0000_0000);
    chk("set1_valid", 1, rd[15]);
  endtask

  initial
  begin
    t_grid();
    t_resistor();
    do_reset(8'h00, 5'h00);
    t_blank();
    t_fast();
    t_pwm();
    t_regs();
    t_adapt();
    chk("overlap", 0, overlap_seen);
    close_out();
  end
endmodule
